// >>> core/tv_port_pkg.sv
// constants, register map and carrier types for the television port pin logic
// Operation
// - direction bit 0 input, 1 output
// - write to output bit updates latch, drives pin
// - output bit reads back the latch
// - input bit floats; read returns pin level
// - write to input bit only updates latch
// - fourth port bits 2,3 pick CMOS/open-drain
// - third port eight bits, same behaviour
// - fourth port two bits, same behaviour
// - fifth port two inputs, also sync inputs
// - fifth port six CMOS outputs, four OSD
// - sixth port eight CMOS output pins
// - I2C mode: four second-port pins open-drain
// - third port carries serial clock, out, in
// - two third-port pins clock timers three, two
// - fourth port pins feed analog inputs five, six
// - second port pins feed analog eight, one-three
// - second port pin feeds external interrupt three
// - oscillator pins double as sub-clock pins
// - reset makes every bidirectional pin input
package tv_port_pkg;
    // register indices on the plain register port
    localparam logic [3:0] ADDR_SECOND_DATA  = 4'h0;
    localparam logic [3:0] ADDR_SECOND_DIR   = 4'h1;
    localparam logic [3:0] ADDR_THIRD_DATA   = 4'h2;
    localparam logic [3:0] ADDR_THIRD_DIR    = 4'h3;
    localparam logic [3:0] ADDR_FOURTH_DATA  = 4'h4;
    localparam logic [3:0] ADDR_FOURTH_DIR   = 4'h5;
    localparam logic [3:0] ADDR_FIFTH_DATA   = 4'h6;
    localparam logic [3:0] ADDR_SIXTH_DATA   = 4'h7;
    localparam logic [3:0] ADDR_ALT_SELECT   = 4'h8;

    // alternate function select bits
    localparam int SEL_I2C        = 0;
    localparam int SEL_SERIAL     = 1;
    localparam int SEL_OSD_COLOUR = 2;
    localparam int SEL_OSD_AUX_B  = 3;
    localparam int SEL_OSD_OSC    = 4;
    localparam int SEL_SUB_CLOCK  = 5;

    // fourth port direction/drive register fields
    localparam int FOURTH_DIR_LSB   = 0;
    localparam int FOURTH_DRIVE_LSB = 2;

    // reset values
    localparam logic [7:0] DIR_RESET   = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] SEL_RESET   = 8'h00;
    localparam logic [7:0] UNMAPPED    = 8'h00;

    // second port pin positions
    localparam int PIN_AUX_B   = 0;
    localparam int PIN_SCL_A   = 1;
    localparam int PIN_SCL_B   = 2;
    localparam int PIN_SDA_A   = 3;
    localparam int PIN_SDA_B   = 4;
    localparam int PIN_EXT_IRQ = 5;
    // third port pin positions
    localparam int PIN_SCLK    = 0;
    localparam int PIN_SOUT    = 1;
    localparam int PIN_SER_IN  = 2;
    localparam int PIN_T3_CLK  = 3;
    localparam int PIN_T2_CLK  = 4;
    localparam int PIN_OSC_IN  = 6;
    localparam int PIN_OSC_OUT = 7;

    // pad drive for one eight-pin port; drive_n low means the pin is driven
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] drive_n;
    } pad_drive_t;

    // pin levels handed to the alternate function units
    typedef struct packed {
        logic       i2c_clock_line_a;
        logic       i2c_clock_line_b;
        logic       i2c_data_line_a;
        logic       i2c_data_line_b;
        logic       ext_interrupt_three;
        logic       serial_clock_in;
        logic       serial_data_in_pin;
        logic       timer_three_ext_clock;
        logic       timer_two_ext_clock;
        logic       osd_osc_input;
        logic       sub_clock_input;
        logic       osd_hsync;
        logic       osd_vsync;
    } alt_in_t;
endpackage : tv_port_pkg

// >>> core/tv_mcu_port_pin_logic.sv
// port pin logic: latches, directions, alternate functions and register port
`timescale 1ns/1ps
`default_nettype none
module tv_mcu_port_pin_logic
    import tv_port_pkg::*;
(
    input  wire logic       I_MCLK,
    input  wire logic       I_RST,
    input  wire logic [3:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    input  wire logic [7:0] I_SECOND_PIN,
    input  wire logic [7:0] I_THIRD_PIN,
    input  wire logic [1:0] I_FOURTH_PIN,
    input  wire logic [1:0] I_FIFTH_PIN,
    input  wire logic       I_I2C_CLOCK_LINE_A,
    input  wire logic       I_I2C_CLOCK_LINE_B,
    input  wire logic       I_I2C_DATA_LINE_A,
    input  wire logic       I_I2C_DATA_LINE_B,
    input  wire logic       I_SERIAL_CLOCK_OUT,
    input  wire logic       I_SERIAL_DATA_OUT,
    input  wire logic [3:0] I_OSD_COLOUR,
    input  wire logic       I_OSD_AUX_OUTPUT_B,
    input  wire logic       I_OSD_OSC_OUTPUT,
    input  wire logic       I_SUB_CLOCK_OUTPUT,
    output logic [7:0]      O_RDATA,
    output pad_drive_t      O_SECOND_PAD,
    output pad_drive_t      O_THIRD_PAD,
    output logic [1:0]      O_FOURTH_LEVEL,
    output logic [1:0]      O_FOURTH_DRIVE_N,
    output logic [5:0]      O_FIFTH_OUT,
    output logic [7:0]      O_SIXTH_OUT,
    output alt_in_t         O_ALT_IN
);

    // one pad group: alternate function wins over latch, open-drain only pulls low
    function automatic pad_drive_t pad_next(
        input logic [7:0] dir,
        input logic [7:0] latch,
        input logic [7:0] alt_en,
        input logic [7:0] alt_val,
        input logic [7:0] od
    );
        logic [7:0] val;
        logic [7:0] drv;
        val = (alt_en & alt_val) | (~alt_en & latch);
        drv = alt_en | dir;
        pad_next.level   = val & ~od;
        pad_next.drive_n = ~(drv & ~(od & val));
    endfunction : pad_next

    logic [7:0] second_latch;
    logic [7:0] second_dir;
    logic [7:0] third_latch;
    logic [7:0] third_dir;
    logic [1:0] fourth_latch;
    logic [7:0] fourth_ctrl;
    logic [5:0] fifth_latch;
    logic [7:0] sixth_latch;
    logic [7:0] alt_sel;

    logic [7:0] second_s1;
    logic [7:0] second_s2;
    logic [7:0] third_s1;
    logic [7:0] third_s2;
    logic [1:0] fourth_s1;
    logic [1:0] fourth_s2;
    logic [1:0] fifth_s1;
    logic [1:0] fifth_s2;

    // address decode
    wire wr_second_data = I_WR && (I_ADDR == ADDR_SECOND_DATA);
    wire wr_second_dir  = I_WR && (I_ADDR == ADDR_SECOND_DIR);
    wire wr_third_data  = I_WR && (I_ADDR == ADDR_THIRD_DATA);
    wire wr_third_dir   = I_WR && (I_ADDR == ADDR_THIRD_DIR);
    wire wr_fourth_data = I_WR && (I_ADDR == ADDR_FOURTH_DATA);
    wire wr_fourth_dir  = I_WR && (I_ADDR == ADDR_FOURTH_DIR);
    wire wr_fifth_data  = I_WR && (I_ADDR == ADDR_FIFTH_DATA);
    wire wr_sixth_data  = I_WR && (I_ADDR == ADDR_SIXTH_DATA);
    wire wr_alt_sel     = I_WR && (I_ADDR == ADDR_ALT_SELECT);

    wire sel_i2c    = alt_sel[SEL_I2C];
    wire sel_serial = alt_sel[SEL_SERIAL];
    wire sel_colour = alt_sel[SEL_OSD_COLOUR];
    wire sel_aux_b  = alt_sel[SEL_OSD_AUX_B];
    wire sel_osc    = alt_sel[SEL_OSD_OSC];
    wire sel_sub    = alt_sel[SEL_SUB_CLOCK];

    wire [1:0] fourth_dir   = fourth_ctrl[FOURTH_DIR_LSB +: 2];
    wire [1:0] fourth_drive = fourth_ctrl[FOURTH_DRIVE_LSB +: 2];

    // read view: output bits give the latch, input bits the synchronised pin
    wire [7:0] second_view = (second_dir & second_latch) | (~second_dir & second_s2);
    wire [7:0] third_view  = (third_dir & third_latch) | (~third_dir & third_s2);
    wire [1:0] fourth_view = (fourth_dir & fourth_latch) | (~fourth_dir & fourth_s2);

    // read mux; unmapped indices answer zero
    logic [7:0] next_rdata;
    always_comb
    begin
        case (I_ADDR)
            ADDR_SECOND_DATA: next_rdata = second_view;
            ADDR_SECOND_DIR:  next_rdata = second_dir;
            ADDR_THIRD_DATA:  next_rdata = third_view;
            ADDR_THIRD_DIR:   next_rdata = third_dir;
            ADDR_FOURTH_DATA: next_rdata = {6'h00, fourth_view};
            ADDR_FOURTH_DIR:  next_rdata = {4'h0, fourth_ctrl[3:0]};
            ADDR_FIFTH_DATA:  next_rdata = {fifth_latch, fifth_s2};
            ADDR_SIXTH_DATA:  next_rdata = sixth_latch;
            ADDR_ALT_SELECT:  next_rdata = {2'h0, alt_sel[5:0]};
            default:          next_rdata = UNMAPPED;
        endcase
    end

    // second port alternates: aux output b on bit 0, I2C lines on bits 1-4
    wire [7:0] second_alt_en  = {3'h0, {4{sel_i2c}}, sel_aux_b};
    wire [7:0] second_alt_val = {3'h0, I_I2C_DATA_LINE_B, I_I2C_DATA_LINE_A,
                                 I_I2C_CLOCK_LINE_B, I_I2C_CLOCK_LINE_A,
                                 I_OSD_AUX_OUTPUT_B};
    wire [7:0] second_od      = {3'h0, {4{sel_i2c}}, 1'h0};

    // third port alternates: serial clock/data out, oscillator or sub-clock out
    wire       osc_drive     = sel_osc | sel_sub;
    wire       osc_val       = sel_osc ? I_OSD_OSC_OUTPUT : I_SUB_CLOCK_OUTPUT;
    wire [7:0] third_alt_en  = {osc_drive, 5'h00, {2{sel_serial}}};
    wire [7:0] third_alt_val = {osc_val, 5'h00, I_SERIAL_DATA_OUT, I_SERIAL_CLOCK_OUT};
    wire [7:0] third_od      = {6'h00, {2{sel_serial}}};

    // the oscillator input pin is never driven by the port in oscillator modes
    wire [7:0] third_dir_eff = third_dir & ~{1'h0, osc_drive, 6'h00};

    wire pad_drive_t next_second = pad_next(second_dir, second_latch, second_alt_en,
                                            second_alt_val, second_od);
    wire pad_drive_t next_third  = pad_next(third_dir_eff, third_latch, third_alt_en,
                                            third_alt_val, third_od);
    wire pad_drive_t next_fourth = pad_next({6'h00, fourth_dir}, {6'h00, fourth_latch},
                                            8'h00, 8'h00, {6'h00, fourth_drive});

    // fifth port outputs: OSD red, green, blue, aux a replace latch bits 0-3
    wire [5:0] next_fifth = {fifth_latch[5:4],
                             sel_colour ? I_OSD_COLOUR : fifth_latch[3:0]};

    // pin synchronisers; only the second stage feeds logic
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            second_s1 <= 8'h00;
            second_s2 <= 8'h00;
            third_s1  <= 8'h00;
            third_s2  <= 8'h00;
            fourth_s1 <= 2'h0;
            fourth_s2 <= 2'h0;
            fifth_s1  <= 2'h0;
            fifth_s2  <= 2'h0;
        end
        else
        begin
            second_s1 <= I_SECOND_PIN;
            second_s2 <= second_s1;
            third_s1  <= I_THIRD_PIN;
            third_s2  <= third_s1;
            fourth_s1 <= I_FOURTH_PIN;
            fourth_s2 <= fourth_s1;
            fifth_s1  <= I_FIFTH_PIN;
            fifth_s2  <= fifth_s1;
        end
    end

    // direction registers; reset leaves every bidirectional pin floating
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            second_dir  <= DIR_RESET;
            third_dir   <= DIR_RESET;
            fourth_ctrl <= DIR_RESET;
            alt_sel     <= SEL_RESET;
        end
        else
        begin
            if (wr_second_dir)
                second_dir <= I_WDATA;
            if (wr_third_dir)
                third_dir <= I_WDATA;
            if (wr_fourth_dir)
                fourth_ctrl <= {4'h0, I_WDATA[3:0]};
            if (wr_alt_sel)
                alt_sel <= {2'h0, I_WDATA[5:0]};
        end
    end

    // port latches take writes whatever the direction; input bits keep floating
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            second_latch <= LATCH_RESET;
            third_latch  <= LATCH_RESET;
            fourth_latch <= 2'h0;
            fifth_latch  <= 6'h00;
            sixth_latch  <= LATCH_RESET;
        end
        else
        begin
            if (wr_second_data)
                second_latch <= I_WDATA;
            if (wr_third_data)
                third_latch <= I_WDATA;
            if (wr_fourth_data)
                fourth_latch <= I_WDATA[1:0];
            if (wr_fifth_data)
                fifth_latch <= I_WDATA[7:2];
            if (wr_sixth_data)
                sixth_latch <= I_WDATA;
        end
    end

    // registered pads and read data; one cycle of delay keeps outputs glitch free
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_RDATA          <= 8'h00;
            O_SECOND_PAD     <= '{level: 8'h00, drive_n: 8'hFF};
            O_THIRD_PAD      <= '{level: 8'h00, drive_n: 8'hFF};
            O_FOURTH_LEVEL   <= 2'h0;
            O_FOURTH_DRIVE_N <= 2'h3;
            O_FIFTH_OUT      <= 6'h00;
            O_SIXTH_OUT      <= 8'h00;
        end
        else
        begin
            O_RDATA          <= I_RD ? next_rdata : 8'h00;
            O_SECOND_PAD     <= next_second;
            O_THIRD_PAD      <= next_third;
            O_FOURTH_LEVEL   <= next_fourth.level[1:0];
            O_FOURTH_DRIVE_N <= next_fourth.drive_n[1:0];
            O_FIFTH_OUT      <= next_fifth;
            O_SIXTH_OUT      <= sixth_latch;
        end
    end

    // pin levels to the function units; analog pins reach the converter directly
    alt_in_t next_alt_in;
    always_comb
    begin
        next_alt_in.i2c_clock_line_a      = second_s2[PIN_SCL_A];
        next_alt_in.i2c_clock_line_b      = second_s2[PIN_SCL_B];
        next_alt_in.i2c_data_line_a       = second_s2[PIN_SDA_A];
        next_alt_in.i2c_data_line_b       = second_s2[PIN_SDA_B];
        next_alt_in.ext_interrupt_three   = second_s2[PIN_EXT_IRQ];
        next_alt_in.serial_clock_in       = third_s2[PIN_SCLK];
        next_alt_in.serial_data_in_pin    = third_s2[PIN_SER_IN];
        next_alt_in.timer_three_ext_clock = third_s2[PIN_T3_CLK];
        next_alt_in.timer_two_ext_clock   = third_s2[PIN_T2_CLK];
        next_alt_in.osd_osc_input         = third_s2[PIN_OSC_IN] & sel_osc;
        next_alt_in.sub_clock_input       = third_s2[PIN_OSC_IN] & sel_sub;
        next_alt_in.osd_hsync             = fifth_s2[0];
        next_alt_in.osd_vsync             = fifth_s2[1];
    end

    // pin levels to the function units registered once more, three cycles after the pins
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
            O_ALT_IN <= '0;
        else
            O_ALT_IN <= next_alt_in;
    end

    // checks
    input_floats_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (second_dir == 8'h00 && !sel_i2c && !sel_aux_b) |=> (O_SECOND_PAD.drive_n == 8'hFF))
        else $error("input bits of second port are driven");

    latch_readback_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (I_RD && I_ADDR == ADDR_THIRD_DATA && third_dir == 8'hFF)
        |=> (O_RDATA == $past(third_latch)))
        else $error("output bit read does not return latch");

    pin_readback_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (I_RD && I_ADDR == ADDR_SECOND_DATA && second_dir == 8'h00)
        |=> (O_RDATA == $past(second_s2)))
        else $error("input bit read does not return pin level");

    latch_drives_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (wr_sixth_data && !I_RST) |=> ##1 (O_SIXTH_OUT == $past(I_WDATA, 2)))
        else $error("sixth port write did not reach its pins in two cycles");

    open_drain_high_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (fourth_drive[0] && fourth_dir[0] && fourth_latch[0])
        |=> (O_FOURTH_DRIVE_N[0] && !O_FOURTH_LEVEL[0]))
        else $error("open-drain fourth port pin drives high");

    i2c_pull_low_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (sel_i2c && !I_I2C_CLOCK_LINE_A)
        |=> (!O_SECOND_PAD.drive_n[PIN_SCL_A] && !O_SECOND_PAD.level[PIN_SCL_A]))
        else $error("I2C clock line a not pulled low");

    i2c_release_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (sel_i2c && I_I2C_DATA_LINE_B) |=> O_SECOND_PAD.drive_n[PIN_SDA_B])
        else $error("I2C data line b driven while released");

    osd_override_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        sel_colour |=> (O_FIFTH_OUT[3:0] == $past(I_OSD_COLOUR)))
        else $error("OSD colour does not override fifth port latch");

    sync_delay_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (!$past(I_RST) && !$past(I_RST, 2) && !$past(I_RST, 3))
        |-> (O_ALT_IN.osd_hsync == $past(I_FIFTH_PIN[0], 3)))
        else $error("horizontal sync not passed in three cycles");

    vsync_delay_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (!$past(I_RST) && !$past(I_RST, 2) && !$past(I_RST, 3))
        |-> (O_ALT_IN.osd_vsync == $past(I_FIFTH_PIN[1], 3)))
        else $error("vertical sync not passed in three cycles");

    // bits 2-5 of the third port have no alternate output, so direction alone decides
    dir_drives_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        1'b1 |=> (O_THIRD_PAD.drive_n[5:2] == ~$past(third_dir[5:2])))
        else $error("third port direction does not set pin drive");

    input_write_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (wr_second_data && second_dir[7:5] == 3'h0 && !wr_second_dir)
        |=> ##1 (O_SECOND_PAD.drive_n[7:5] == 3'h7))
        else $error("write to input bits drove the pins");

    fourth_readback_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (I_RD && I_ADDR == ADDR_FOURTH_DATA && fourth_dir == 2'h3)
        |=> (O_RDATA == {6'h00, $past(fourth_latch)}))
        else $error("fourth port output read does not return latch");

    cmos_drive_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (!fourth_drive[1] && fourth_dir[1])
        |=> (!O_FOURTH_DRIVE_N[1] && O_FOURTH_LEVEL[1] == $past(fourth_latch[1])))
        else $error("push-pull fourth port pin not driven from latch");

    fifth_high_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        wr_fifth_data |=> ##1 (O_FIFTH_OUT[5:4] == $past(I_WDATA[7:6], 2)))
        else $error("fifth port upper outputs not updated");

    serial_clock_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (sel_serial && !I_SERIAL_CLOCK_OUT)
        |=> (!O_THIRD_PAD.drive_n[PIN_SCLK] && !O_THIRD_PAD.level[PIN_SCLK]))
        else $error("serial clock pin not pulled low");

    timer_two_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (!$past(I_RST) && !$past(I_RST, 2) && !$past(I_RST, 3))
        |-> (O_ALT_IN.timer_two_ext_clock == $past(I_THIRD_PIN[PIN_T2_CLK], 3)))
        else $error("timer two clock pin not passed in three cycles");

    int_three_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (!$past(I_RST) && !$past(I_RST, 2) && !$past(I_RST, 3))
        |-> (O_ALT_IN.ext_interrupt_three == $past(I_SECOND_PIN[PIN_EXT_IRQ], 3)))
        else $error("interrupt pin not passed in three cycles");

    sub_clock_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (sel_sub && !sel_osc)
        |=> (!O_THIRD_PAD.drive_n[PIN_OSC_OUT]
             && O_THIRD_PAD.level[PIN_OSC_OUT] == $past(I_SUB_CLOCK_OUTPUT)))
        else $error("sub-clock output does not reach its pin");

    reset_float_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        $past(I_RST) |-> (second_dir == 8'h00 && third_dir == 8'h00 && fourth_dir == 2'h0
            && O_SECOND_PAD.drive_n == 8'hFF && O_THIRD_PAD.drive_n == 8'hFF
            && O_FOURTH_DRIVE_N == 2'h3))
        else $error("bidirectional pins not floating after reset");

    aux_output_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        sel_aux_b |=> (!O_SECOND_PAD.drive_n[PIN_AUX_B]
            && O_SECOND_PAD.level[PIN_AUX_B] == $past(I_OSD_AUX_OUTPUT_B)))
        else $error("aux output b does not override second port latch");

endmodule : tv_mcu_port_pin_logic
`default_nettype wire

// >>> sim/tv_port_board.sv
// board model: pull-ups, an external source and an LED load on the port pins
`timescale 1ns/1ps
`default_nettype none
module tv_port_board
    import tv_port_pkg::*;
(
    input  wire pad_drive_t i_second_pad,
    input  wire pad_drive_t i_third_pad,
    input  wire logic [1:0] i_fourth_level,
    input  wire logic [1:0] i_fourth_drive_n,
    input  wire logic [7:0] i_src_val,
    input  wire logic [7:0] i_src_en,
    input  wire logic [7:0] i_sag,
    output logic [7:0]      o_second_pin,
    output logic [7:0]      o_third_pin,
    output logic [1:0]      o_fourth_pin
);
    // a driven pin shows the pad level; the LED load drags a high second-port pin low,
    // so a readback of the pin would differ from the latch
    // released pins see the board source or else the pull-up, never a stale value
    assign o_second_pin = (~i_second_pad.drive_n & i_second_pad.level & ~i_sag)
                        | (i_second_pad.drive_n & (~i_src_en | i_src_val));
    assign o_third_pin  = (~i_third_pad.drive_n & i_third_pad.level)
                        | (i_third_pad.drive_n & (~i_src_en | i_src_val));
    // open-drain release on the fourth port floats up to the pull-up
    assign o_fourth_pin = (~i_fourth_drive_n & i_fourth_level) | i_fourth_drive_n;
endmodule : tv_port_board
`default_nettype wire

// >>> sim/tb_tv_mcu_port_pin_logic.sv
// self-checking testbench for the television port pin logic
`timescale 1ns/1ps
`default_nettype none
module tb_tv_mcu_port_pin_logic;
    import tv_port_pkg::*;
    logic       clk, rst, wr, rd, sclk_o, sdat_o, aux_b, osc_o, sub_o;
    logic [3:0] addr, i2c, colour;
    logic [7:0] wdata, src_val, src_en, sag, rdata, sixth_out, second_pin, third_pin;
    logic [7:0] d;
    logic [1:0] fifth_pin, f4_level, f4_dn, fourth_pin;
    logic [5:0] fifth_out;
    pad_drive_t second_pad, third_pad;
    alt_in_t    alt_in;
    int         bad_count, n_compared, cycles;

    tv_mcu_port_pin_logic u_dut (.I_MCLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .I_SECOND_PIN(second_pin), .I_THIRD_PIN(third_pin),
        .I_FOURTH_PIN(fourth_pin), .I_FIFTH_PIN(fifth_pin), .I_I2C_CLOCK_LINE_A(i2c[0]),
        .I_I2C_CLOCK_LINE_B(i2c[1]), .I_I2C_DATA_LINE_A(i2c[2]), .I_I2C_DATA_LINE_B(i2c[3]),
        .I_SERIAL_CLOCK_OUT(sclk_o), .I_SERIAL_DATA_OUT(sdat_o), .I_OSD_COLOUR(colour),
        .I_OSD_AUX_OUTPUT_B(aux_b), .I_OSD_OSC_OUTPUT(osc_o), .I_SUB_CLOCK_OUTPUT(sub_o),
        .O_RDATA(rdata), .O_SECOND_PAD(second_pad), .O_THIRD_PAD(third_pad),
        .O_FOURTH_LEVEL(f4_level), .O_FOURTH_DRIVE_N(f4_dn), .O_FIFTH_OUT(fifth_out),
        .O_SIXTH_OUT(sixth_out), .O_ALT_IN(alt_in));

    tv_port_board u_board (.i_second_pad(second_pad), .i_third_pad(third_pad),
        .i_fourth_level(f4_level), .i_fourth_drive_n(f4_dn), .i_src_val(src_val),
        .i_src_en(src_en), .i_sag(sag), .o_second_pin(second_pin),
        .o_third_pin(third_pin), .o_fourth_pin(fourth_pin));

    // 200 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            summarize();
        end
    end

    task automatic summarize();
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one-cycle write strobe; the slave never stalls
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(16'(rdata), 16'(exp));
    endtask : rd_check

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic board(input logic [7:0] v, input logic [7:0] en, input logic [7:0] s);
        @(posedge clk);
        src_val <= v;
        src_en  <= en;
        sag     <= s;
    endtask : board

    initial
    begin
        rst = 1'b1;
        {wr, rd, addr, wdata, sclk_o, sdat_o, aux_b, osc_o, sub_o} = '0;
        {src_val, src_en, sag, fifth_pin, colour} = '0;
        i2c = 4'hF;
        bad_count = 0;
        n_compared = 0;
        cycles = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        // after reset every bidirectional pin floats
        check({second_pad.drive_n, third_pad.drive_n}, 16'hFFFF);
        check(16'(f4_dn), 16'h0003);
        rd_check(ADDR_SECOND_DIR, DIR_RESET);
        rd_check(ADDR_THIRD_DIR, DIR_RESET);
        rd_check(ADDR_FOURTH_DIR, DIR_RESET);
        // an unmapped index keeps nothing
        wr_reg(4'h9, 8'hFF);
        rd_check(4'h9, UNMAPPED);
        // second port: latch written while input, pin stays floating
        wr_reg(ADDR_SECOND_DATA, 8'h5A);
        settle(1);
        check(16'(second_pad.drive_n), 16'h00FF);
        board(8'hC3, 8'hFF, 8'h00);
        settle(3);
        rd_check(ADDR_SECOND_DATA, 8'hC3);
        // low nibble becomes output; the load sags bit 1 but readback keeps the latch
        wr_reg(ADDR_SECOND_DIR, 8'h0F);
        board(8'hC3, 8'hFF, 8'h02);
        settle(3);
        check(16'(second_pad.drive_n), 16'h00F0);
        check(16'(second_pad.level[3:0]), 16'h000A);
        rd_check(ADDR_SECOND_DATA, 8'hCA);
        // third port: all eight bits as outputs
        wr_reg(ADDR_THIRD_DIR, 8'hFF);
        wr_reg(ADDR_THIRD_DATA, 8'h3C);
        settle(1);
        check(third_pad, 16'h3C00);
        rd_check(ADDR_THIRD_DATA, 8'h3C);
        // fourth port: CMOS first, then open-drain where a latched 1 lets go
        wr_reg(ADDR_FOURTH_DIR, 8'h03);
        wr_reg(ADDR_FOURTH_DATA, 8'h02);
        settle(1);
        check(16'({f4_level, f4_dn}), 16'h0008);
        wr_reg(ADDR_FOURTH_DIR, 8'h0F);
        settle(1);
        check(16'({f4_level[0], f4_dn}), 16'h0002);
        rd_check(ADDR_FOURTH_DIR, 8'h0F);
        rd_check(ADDR_FOURTH_DATA, 8'h02);
        // fifth port: two sync inputs, six outputs
        @(posedge clk);
        fifth_pin <= 2'b01;
        wr_reg(ADDR_FIFTH_DATA, 8'hA8);
        settle(1);
        check(16'(fifth_out), 16'h002A);
        rd_check(ADDR_FIFTH_DATA, 8'hA9);
        check(16'({alt_in.osd_hsync, alt_in.osd_vsync}), 16'h0002);
        // sixth port
        wr_reg(ADDR_SIXTH_DATA, 8'hA5);
        settle(1);
        check(16'(sixth_out), 16'h00A5);
        // alternate functions are chosen by software through the select register
        wr_reg(ADDR_SECOND_DIR, 8'h00);
        @(posedge clk);
        i2c <= 4'b1110;
        wr_reg(ADDR_ALT_SELECT, 8'h01);
        settle(1);
        check(16'({second_pad.drive_n[4:1], second_pad.level[1]}), 16'h001C);
        // third port goes to input before the serial unit takes its pins
        wr_reg(ADDR_THIRD_DIR, 8'h00);
        @(posedge clk);
        sdat_o <= 1'b1;
        wr_reg(ADDR_ALT_SELECT, 8'h02);
        board(8'h74, 8'hFF, 8'h00);
        settle(4);
        check(16'({third_pad.drive_n[1:0], third_pad.level[0]}), 16'h0004);
        check(16'({alt_in.serial_data_in_pin, alt_in.timer_three_ext_clock}), 16'h0002);
        check(16'(alt_in.timer_two_ext_clock), 16'h0001);
        check(16'(alt_in.ext_interrupt_three), 16'h0001);
        check(16'({alt_in.osd_osc_input, alt_in.sub_clock_input}), 16'h0000);
        @(posedge clk);
        colour <= 4'h9;
        wr_reg(ADDR_ALT_SELECT, 8'h04);
        settle(1);
        check(16'(fifth_out), 16'h0029);
        @(posedge clk);
        aux_b <= 1'b1;
        wr_reg(ADDR_ALT_SELECT, 8'h08);
        settle(1);
        check(16'({second_pad.level[0], second_pad.drive_n[0]}), 16'h0002);
        @(posedge clk);
        osc_o <= 1'b1;
        wr_reg(ADDR_ALT_SELECT, 8'h10);
        settle(1);
        check(16'({third_pad.level[7], third_pad.drive_n[7]}), 16'h0002);
        check(16'({alt_in.osd_osc_input, alt_in.sub_clock_input}), 16'h0002);
        wr_reg(ADDR_ALT_SELECT, 8'h20);
        settle(1);
        check(16'({third_pad.level[7], third_pad.drive_n[7]}), 16'h0000);
        check(16'({alt_in.osd_osc_input, alt_in.sub_clock_input}), 16'h0001);
        summarize();
    end
endmodule : tb_tv_mcu_port_pin_logic
`default_nettype wire
